// ### core/cspc_clock_ctrl.v
/*
 * clock source selection, main loop control, core/usb/peripheral dividers.
 * assumes an ahb-lite master, one 25 mhz clock, oscillator and loop lock as
 * synchronous inputs, and power-state requests from the power manager.
 */
// The implementer's own choices: the register addresses and the AHB-Lite register port.
// Functional notes
// - after reset the internal rc oscillator is the source until software changes it
// - software selects rc, main or rtc oscillator as loop reference
// - rc oscillator may clock the watchdog and be loop reference
// - main oscillator may reach core through loop or bypassing it
// - only the main oscillator feeds the usb loop reference
// - core clock equals reference unless loop enabled, connected and locked
// - each peripheral has its own software divider setting
// - rtc oscillator may clock rtc, be loop reference, or clock core
// - pre-divider n programmable from 1 to 256
// - feedback multiplier m programmable from 1 to 32768
// - loop divides oscillator by m, compares with pre-divided reference
// - post-divider derives core and usb clocks from loop oscillator
// - loop disabled and bypassed after reset and at power-down
// - loop enabled only by a software write, never by hardware
// - usb clock comes from main loop while usb loop disabled
// - deep-sleep turns loop off, disconnects, clears core and usb dividers
// - deep-sleep wake holds execution 4 rc or 4096 main cycles
`timescale 1ns/10ps
`include "cspc_map.vh"
module cspc_clock_ctrl #(
    parameter NPER = 8,
    parameter DIVW = 8,
    parameter WAKE_MAIN = 4096
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // oscillator ticks and loop status
    input wire irc_tick,
    input wire main_tick,
    input wire loop_lock,
    // power states
    input wire deep_sleep_enter,
    input wire power_down_enter,
    input wire wake,
    // loop controls
    output reg [1:0] loop_reference_sel,
    output reg [7:0] loop_prediv,
    output reg [14:0] loop_mult,
    output reg loop_enable,
    output reg loop_connect,
    output reg core_from_loop,
    output reg core_from_ref,
    output reg [7:0] core_div,
    output reg [7:0] usb_div,
    output reg usb_from_main_loop,
    output reg usb_loop_ref_main,
    output reg watchdog_clock_irc,
    output reg watchdog_clock_rtc,
    output reg rtc_clock_en,
    output reg [2*NPER-1:0] pclk_sel,
    output reg [NPER-1:0] pclk_en,
    output reg exec_hold
);
    // ****************************************************
    // bus decode
    // ****************************************************
    reg ph_wr;
    reg ph_rd;
    reg [11:0] ph_addr;
    reg [1:0] src;
    reg ctl_en;
    reg ctl_conn;
    reg [7:0] pre_n;
    reg [14:0] mul_m;
    reg [7:0] cdiv;
    reg [7:0] udiv;
    reg [2*NPER-1:0] psel;
    reg [3:0] misc;
    reg feed_armed;
    reg [1:0] act_en_conn;
    reg asleep;
    reg sleep_src_main;
    reg [12:0] wake_cnt;
    reg [DIVW-1:0] pcnt [0:NPER-1];
    wire acc = hsel && hready && htrans[1];
    wire en_eff = act_en_conn[0];
    wire conn_eff = act_en_conn[0] & act_en_conn[1] & loop_lock;
    wire mux_a;
    wire mux_b;
    reg [31:0] next_rdata;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 12'h000;
        end else begin
            ph_wr <= acc && hwrite;
            ph_rd <= acc && !hwrite;
            ph_addr <= haddr;
        end
    end

    // ****************************************************
    // register writes and power-state effects
    // ****************************************************
    // enable/connect take effect only after the feed pair, so a stray write
    // cannot start the loop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src <= `CSPC_SRC_IRC;
            ctl_en <= 1'b0;
            ctl_conn <= 1'b0;
            pre_n <= `CSPC_PRE_RST;
            mul_m <= `CSPC_MUL_RST;
            cdiv <= 8'h00;
            udiv <= 8'h00;
            psel <= {2*NPER{1'b0}};
            misc <= 4'h0;
            feed_armed <= 1'b0;
            act_en_conn <= 2'b00;
        end else begin
            if (ph_wr) begin
                case (ph_addr)
                    `CSPC_SRCSEL_OFF: src <= (hwdata[1:0] == 2'h3) ? src : hwdata[1:0];
                    `CSPC_LOOPCTL_OFF: begin
                        ctl_en <= hwdata[`CSPC_CTL_EN];
                        ctl_conn <= hwdata[`CSPC_CTL_CONN];
                    end
                    `CSPC_LOOPCFG_OFF: begin
                        mul_m <= hwdata[14:0];
                        pre_n <= hwdata[23:16];
                    end
                    `CSPC_CORDIV_OFF: cdiv <= hwdata[7:0];
                    `CSPC_USBDIV_OFF: udiv <= hwdata[7:0];
                    `CSPC_PCLKSEL_OFF: psel <= hwdata[2*NPER-1:0];
                    `CSPC_MISC_OFF: misc <= hwdata[3:0];
                    default: ;
                endcase
            end
            if (ph_wr && ph_addr == `CSPC_LOOPFEED_OFF) begin
                if (feed_armed && hwdata[7:0] == `CSPC_FEED_KEY2) begin
                    act_en_conn <= {ctl_conn & ctl_en, ctl_en};
                end
                feed_armed <= (hwdata[7:0] == `CSPC_FEED_KEY1);
            end else if (ph_wr) begin
                feed_armed <= 1'b0;
            end
            if (deep_sleep_enter || power_down_enter) begin
                ctl_en <= 1'b0;
                ctl_conn <= 1'b0;
                act_en_conn <= 2'b00;
                cdiv <= 8'h00;
                udiv <= 8'h00;
            end
        end
    end

    // ****************************************************
    // wake-up hold
    // ****************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            asleep <= 1'b0;
            sleep_src_main <= 1'b0;
            wake_cnt <= 13'h0000;
            exec_hold <= 1'b0;
        end else begin
            if (deep_sleep_enter) begin
                asleep <= 1'b1;
                sleep_src_main <= (src == `CSPC_SRC_MAIN);
                exec_hold <= 1'b1;
            end else if (asleep && wake) begin
                asleep <= 1'b0;
                wake_cnt <= sleep_src_main ? WAKE_MAIN[12:0] : `CSPC_WAKE_IRC;
            end else if (!asleep && exec_hold) begin
                if (wake_cnt == 13'h0000) begin
                    exec_hold <= 1'b0;
                end else if (sleep_src_main ? main_tick : irc_tick) begin
                    wake_cnt <= wake_cnt - 13'h0001;
                end
            end
        end
    end

    // ****************************************************
    // glitch-free core path switch
    // ****************************************************
    cspc_glitchless_mux u_mux (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel_b(conn_eff),
        .en_a(mux_a),
        .en_b(mux_b)
    );

    // ****************************************************
    // peripheral clock enables
    // ****************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NPER; gi = gi + 1) begin : g_per
            // select 0..3 gives divide by 4,1,2,8
            wire [1:0] s = psel[2*gi+1:2*gi];
            wire [DIVW-1:0] lim = (s == 2'h1) ? {DIVW{1'b0}} : (s == 2'h2) ? {{(DIVW-1){1'b0}}, 1'b1} :
                (s == 2'h3) ? {{(DIVW-3){1'b0}}, 3'h7} : {{(DIVW-2){1'b0}}, 2'h3};
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pcnt[gi] <= {DIVW{1'b0}};
                    pclk_en[gi] <= 1'b0;
                end else begin
                    pclk_en[gi] <= (pcnt[gi] >= lim);
                    pcnt[gi] <= (pcnt[gi] >= lim) ? {DIVW{1'b0}} : pcnt[gi] + {{(DIVW-1){1'b0}}, 1'b1};
                end
            end
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pclk_sel[2*gi+1:2*gi] <= 2'h0;
                end else begin
                    pclk_sel[2*gi+1:2*gi] <= s;
                end
            end
        end
    endgenerate

    // ****************************************************
    // clock routing outputs
    // ****************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_reference_sel <= `CSPC_SRC_IRC;
            loop_prediv <= 8'h00;
            loop_mult <= 15'h0000;
            loop_enable <= 1'b0;
            loop_connect <= 1'b0;
            core_from_loop <= 1'b0;
            core_from_ref <= 1'b1;
            core_div <= 8'h00;
            usb_div <= 8'h00;
            usb_from_main_loop <= 1'b1;
            usb_loop_ref_main <= 1'b1;
            watchdog_clock_irc <= 1'b1;
            watchdog_clock_rtc <= 1'b0;
            rtc_clock_en <= 1'b1;
        end else begin
            loop_reference_sel <= src;
            loop_prediv <= pre_n;
            loop_mult <= mul_m;
            loop_enable <= en_eff;
            loop_connect <= mux_b;
            core_from_loop <= mux_b;
            core_from_ref <= mux_a;
            core_div <= cdiv;
            usb_div <= udiv;
            usb_from_main_loop <= ~misc[`CSPC_MISC_USBLOOP];
            usb_loop_ref_main <= 1'b1;
            watchdog_clock_irc <= ~misc[`CSPC_MISC_WDRTC] & ~misc[`CSPC_MISC_WDIRC] | misc[`CSPC_MISC_WDIRC];
            watchdog_clock_rtc <= misc[`CSPC_MISC_WDRTC] & ~misc[`CSPC_MISC_WDIRC];
            rtc_clock_en <= 1'b1;
        end
    end

    // ****************************************************
    // read data
    // ****************************************************
    always @* begin
        next_rdata = 32'h0000_0000;
        case (haddr)
            `CSPC_SRCSEL_OFF: next_rdata = {30'h0000_0000, src};
            `CSPC_LOOPCTL_OFF: next_rdata = {30'h0000_0000, ctl_conn, ctl_en};
            `CSPC_LOOPCFG_OFF: next_rdata = {8'h00, pre_n, 1'b0, mul_m};
            `CSPC_LOOPSTAT_OFF: next_rdata = {28'h000_0000, exec_hold, loop_lock, mux_b, en_eff};
            `CSPC_CORDIV_OFF: next_rdata = {24'h00_0000, cdiv};
            `CSPC_USBDIV_OFF: next_rdata = {24'h00_0000, udiv};
            `CSPC_PCLKSEL_OFF: next_rdata = {{(32-2*NPER){1'b0}}, psel};
            `CSPC_MISC_OFF: next_rdata = {28'h000_0000, misc};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (acc && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end
endmodule

// ### core/cspc_glitchless_mux.v
/*
 * glitch-free two-way clock select modelled as enable handshake.
 * assumes select follows loop enable, connect and lock; enables cross one at a time.
 */
`timescale 1ns/10ps
module cspc_glitchless_mux (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // selection
    input wire sel_b,
    // enables for the two clock paths
    output reg en_a,
    output reg en_b
);
    // ****************************************************
    // break before make
    // ****************************************************
    // one path is dropped fully before the other starts, so no runt pulse
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_a <= 1'b1;
            en_b <= 1'b0;
        end else if (sel_b) begin
            en_a <= 1'b0;
            en_b <= ~en_a;
        end else begin
            en_b <= 1'b0;
            en_a <= ~en_b;
        end
    end
endmodule

// ### core/cspc_map.vh
/*
 * register offsets, field positions, reset values and timing counts of the
 * clock source and main loop control block.
 * assumes a 32-bit ahb-lite slave with word-aligned registers.
 */
`ifndef CSPC_MAP_VH
`define CSPC_MAP_VH

// ****************************************************
// register byte offsets
// ****************************************************
`define CSPC_SRCSEL_OFF 12'h000
`define CSPC_LOOPCTL_OFF 12'h004
`define CSPC_LOOPCFG_OFF 12'h008
`define CSPC_LOOPSTAT_OFF 12'h00C
`define CSPC_LOOPFEED_OFF 12'h010
`define CSPC_CORDIV_OFF 12'h014
`define CSPC_USBDIV_OFF 12'h018
`define CSPC_PCLKSEL_OFF 12'h01C
`define CSPC_MISC_OFF 12'h020

// ****************************************************
// source codes
// ****************************************************
`define CSPC_SRC_IRC 2'h0
`define CSPC_SRC_MAIN 2'h1
`define CSPC_SRC_RTC 2'h2

// ****************************************************
// field positions
// ****************************************************
`define CSPC_CTL_EN 0
`define CSPC_CTL_CONN 1
`define CSPC_STAT_EN 0
`define CSPC_STAT_CONN 1
`define CSPC_STAT_LOCK 2
`define CSPC_STAT_HOLD 3
`define CSPC_MISC_WDIRC 0
`define CSPC_MISC_WDRTC 1
`define CSPC_MISC_BYPMAIN 2
`define CSPC_MISC_USBLOOP 3

// ****************************************************
// reset values and wake-up counts
// ****************************************************
`define CSPC_MUL_RST 15'h0000
`define CSPC_PRE_RST 8'h00
`define CSPC_FEED_KEY1 8'hAA
`define CSPC_FEED_KEY2 8'h55
`define CSPC_WAKE_IRC 13'h0004
`define CSPC_WAKE_MAIN 13'h1000

`endif

// ### testbench/cspc_clock_ctrl_test.sv
/* bench for cspc_clock_ctrl: ahb-lite master tasks, one task per test.
   assumes the bound checker and the consumer model beside the design. */
`timescale 1ns/10ps
`include "cspc_map.vh"
module cspc_clock_ctrl_test;
    reg hclk, hresetn, hsel, hwrite, ds, pd, wake, lock_block, cnt_clr;
    reg [11:0] haddr;
    reg [1:0] htrans;
    reg [31:0] hwdata, rd;
    wire [31:0] hrdata, pcnt;
    wire hreadyout, internal_rc_oscillator, mtick, lock, en, conn, from_loop, from_ref, usb_main, usb_ref, wd_irc, wd_rtc, rtc_en, hold;
    wire [1:0] src;
    wire [7:0] prediv, cdiv, udiv, pen;
    wire [14:0] mult;
    wire [15:0] psel;
    wire hresp;
    integer bad_count, checks_done, n;
    cspc_clock_ctrl #(.NPER(8), .DIVW(8), .WAKE_MAIN(8)) cspc_clock_ctrl_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irc_tick(internal_rc_oscillator), .main_tick(mtick),
        .loop_lock(lock), .deep_sleep_enter(ds), .power_down_enter(pd), .wake(wake), .loop_reference_sel(src),
        .loop_prediv(prediv), .loop_mult(mult), .loop_enable(en), .loop_connect(conn), .core_from_loop(from_loop),
        .core_from_ref(from_ref), .core_div(cdiv), .usb_div(udiv), .usb_from_main_loop(usb_main),
        .usb_loop_ref_main(usb_ref), .watchdog_clock_irc(wd_irc), .watchdog_clock_rtc(wd_rtc),
        .rtc_clock_en(rtc_en), .pclk_sel(psel), .pclk_en(pen), .exec_hold(hold));
    cspc_consumer_model cspc_consumer_model_i (.hclk(hclk), .hresetn(hresetn), .loop_enable(en),
        .pclk_en(pen[3:0]), .lock_block(lock_block), .cnt_clr(cnt_clr), .irc_tick(internal_rc_oscillator), .main_tick(mtick),
        .loop_lock(lock), .pcnt(pcnt));
    // ********
    // shared tasks
    // ********
    task chk(input [8*8-1:0] name, input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    // one single transfer; two idle cycles after let registered outputs land
    task bus(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        repeat (2) @(posedge hclk);
        #1;
    end
    endtask
    task feed;
    begin
        bus(1'h1, `CSPC_LOOPFEED_OFF, 32'h0000_00aa);
        bus(1'h1, `CSPC_LOOPFEED_OFF, 32'h0000_0055);
    end
    endtask
    task pulse(input [1:0] w);
    begin
        @(posedge hclk);
        ds <= (w == 2'h0);
        pd <= (w == 2'h1);
        wake <= (w == 2'h2);
        @(posedge hclk);
        ds <= 1'b0;
        pd <= 1'b0;
        wake <= 1'b0;
        // registered outputs follow the event two edges later
        repeat (2) @(posedge hclk);
        #1;
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    end
    endtask
    // ********
    // tests
    // ********
    task t_src;
    begin
        chk("reset", {src, en, conn, from_loop, from_ref}, 5'h01);
        chk("reset io", {usb_ref, usb_main, wd_irc, rtc_en}, 4'hf);
        for (n = 2; n >= 0; n = n - 1) begin
            bus(1'h1, `CSPC_SRCSEL_OFF, n);
            chk("src", src, n);
        end
        bus(1'h1, `CSPC_SRCSEL_OFF, 32'h0000_0003);
        chk("src bad", src, 2'h0);
        bus(1'h1, `CSPC_LOOPCFG_OFF, 32'h00ff_7fff);
        bus(1'h0, `CSPC_LOOPCFG_OFF, 32'h0000_0000);
        chk("cfg rd", rd, 32'h00ff_7fff);
        chk("cfg max", {prediv, mult}, 23'h7f_ffff);
        bus(1'h1, `CSPC_LOOPCFG_OFF, 32'h0000_0000);
        chk("cfg min", {prediv, mult}, 23'h00_0000);
        $display("test source and config done");
    end
    endtask
    task t_loop;
    begin
        // software configures the loop inside its legal ranges before enabling it
        bus(1'h1, `CSPC_LOOPCFG_OFF, 32'h0000_0063);
        bus(1'h1, `CSPC_LOOPCTL_OFF, 32'h0000_0001);
        chk("no feed", en, 1'h0);
        feed;
        chk("enable", en, 1'h1);
        bus(1'h1, `CSPC_LOOPCTL_OFF, 32'h0000_0003);
        feed;
        bus(1'h0, `CSPC_LOOPSTAT_OFF, 32'h0000_0000);
        chk("no lock", {conn, from_loop, rd[2:0]}, 5'h01);
        lock_block <= 1'b0;
        repeat (20) @(posedge hclk);
        bus(1'h0, `CSPC_LOOPSTAT_OFF, 32'h0000_0000);
        chk("lock", rd[2], 1'h1);
        bus(1'h1, `CSPC_LOOPCTL_OFF, 32'h0000_0003);
        feed;
        repeat (4) @(posedge hclk);
        chk("on loop", {conn, from_loop, from_ref}, 3'h6);
        $display("test loop done");
    end
    endtask
    task t_div;
    begin
        bus(1'h1, `CSPC_CORDIV_OFF, 32'h0000_0003);
        bus(1'h1, `CSPC_USBDIV_OFF, 32'h0000_0005);
        chk("divs", {cdiv, udiv}, 16'h0305);
        bus(1'h1, `CSPC_PCLKSEL_OFF, 32'h0000_008d);
        chk("psel", psel[7:0], 8'h8d);
        repeat (16) @(posedge hclk);
        cnt_clr <= 1'b1;
        @(posedge hclk);
        cnt_clr <= 1'b0;
        repeat (64) @(posedge hclk);
        #1;
        chk("pclk", pcnt, 32'h2010_0840);
        $display("test dividers done");
    end
    endtask
    task t_sleep(input m);
    begin
        bus(1'h1, `CSPC_SRCSEL_OFF, {31'h0, m});
        bus(1'h1, `CSPC_USBDIV_OFF, 32'h0000_0005);
        pulse(2'h0);
        chk("sleep", {en, conn, cdiv, udiv, hold}, 19'h0_0001);
        pulse(2'h2);
        repeat (m ? 12 : 4) @(posedge hclk);
        #1;
        chk("held", hold, 1'h1);
        for (n = 0; n < 300 && hold === 1'b1; n = n + 1) @(posedge hclk);
        #1;
        chk("woke", hold, 1'h0);
        $display("test sleep %0d done", m);
    end
    endtask
    task t_misc;
    begin
        bus(1'h1, `CSPC_CORDIV_OFF, 32'h0000_0003);
        pulse(2'h1);
        chk("pdown", {en, conn, cdiv}, 10'h000);
        pulse(2'h2);
        bus(1'h1, `CSPC_SRCSEL_OFF, 32'h0000_0001);
        chk("bypass", {src, from_loop, from_ref}, 4'h5);
        bus(1'h1, `CSPC_MISC_OFF, 32'h0000_000a);
        chk("misc", {wd_irc, wd_rtc, usb_main}, 3'h2);
        bus(1'h1, 12'h100, 32'hffff_ffff);
        bus(1'h0, 12'h100, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        chk("wd kept", {wd_irc, wd_rtc}, 2'h1);
        chk("hresp", hresp, 1'h0);
        $display("test misc done");
    end
    endtask
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        #(40 * 20000);
        bad_count = bad_count + 1;
        end_sim;
    end
    initial begin
        {hresetn, hsel, hwrite, ds, pd, wake, cnt_clr} = 7'h00;
        lock_block = 1'b1;
        haddr = 12'h000;
        htrans = 2'h0;
        hwdata = 32'h0000_0000;
        bad_count = 0;
        checks_done = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        t_src;
        t_loop;
        t_div;
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_misc;
        end_sim;
    end
endmodule

// ### testbench/cspc_consumer_model.sv
/* far side: oscillator ticks, loop lock, peripheral clock users.
   assumes hclk from the bench; lock_block is a bench command. */
`timescale 1ns/10ps
module cspc_consumer_model (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // from block and bench
    input wire loop_enable,
    input wire [3:0] pclk_en,
    input wire lock_block,
    input wire cnt_clr,
    // ticks and lock
    output reg irc_tick,
    output reg main_tick,
    output reg loop_lock,
    // pulse counts, one byte per user
    output reg [31:0] pcnt
);
    reg [1:0] m3;
    reg [3:0] lk;
    integer k;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irc_tick <= 1'b0;
            main_tick <= 1'b0;
            m3 <= 2'h0;
            lk <= 4'h0;
            loop_lock <= 1'b0;
            pcnt <= 32'h0000_0000;
        end else begin
            irc_tick <= ~irc_tick;
            m3 <= (m3 == 2'h2) ? 2'h0 : m3 + 2'h1;
            main_tick <= (m3 == 2'h2);
            // lock only after some cycles enabled, so early connects meet no lock
            lk <= (loop_enable && !lock_block) ? lk + {3'h0, lk != 4'hf} : 4'h0;
            loop_lock <= (lk > 4'h9);
            for (k = 0; k < 4; k = k + 1)
                pcnt[8*k +: 8] <= cnt_clr ? 8'h00 : pcnt[8*k +: 8] + {7'h00, pclk_en[k]};
        end
    end
endmodule

// ### testbench/cspc_ctrl_assertions.sv
/* port checker for cspc_clock_ctrl.
   assumes one clock, hclk, and the bind at the foot. */
`timescale 1ns/10ps
module cspc_ctrl_checker (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // requests and power events
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire loop_lock,
    input wire deep_sleep_enter,
    input wire wake,
    // clock controls
    input wire [1:0] loop_reference_sel,
    input wire loop_enable,
    input wire loop_connect,
    input wire core_from_loop,
    input wire core_from_ref,
    input wire [7:0] core_div,
    input wire [7:0] usb_div,
    input wire exec_hold
);
    reg [3:0] wr_age;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // cycles since the last write request, saturating
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wr_age <= 4'hf;
        else if (hsel && htrans[1] && hwrite)
            wr_age <= 4'h0;
        else if (wr_age != 4'hf)
            wr_age <= wr_age + 4'h1;
    end
    sequence s_wake;
        wake && exec_hold;
    endsequence
    sequence s_held;
        exec_hold [*3];
    endsequence
    // outputs are registered copies, and the connect path passes the break-before-make stage
    sequence s_cleared;
        !loop_enable && !loop_connect && core_div == 8'h00 && usb_div == 8'h00;
    endsequence
    a_src_by_write: assert property (!$stable(loop_reference_sel) |-> wr_age < 4'h6)
        else $error("source changed with no write");
    a_enable_by_write: assert property ($rose(loop_enable) |-> wr_age < 4'h8)
        else $error("loop enabled with no write");
    a_connect_needs_lock: assert property ($rose(loop_connect) |-> $past(loop_lock))
        else $error("connect without lock");
    a_core_loop_gated: assert property ($rose(core_from_loop) |-> loop_enable && loop_connect)
        else $error("core on loop while not enabled and connected");
    a_paths_apart: assert property (!(core_from_loop && core_from_ref))
        else $error("both core paths on");
    a_sleep_clears: assert property (deep_sleep_enter |=> exec_hold ##2 s_cleared)
        else $error("deep sleep left loop or dividers set");
    a_hold_min: assert property (s_wake |=> s_held)
        else $error("hold released too early");
    a_hold_end: assert property (s_wake |-> ##[1:300] !exec_hold)
        else $error("hold never released");
endmodule
bind cspc_clock_ctrl cspc_ctrl_checker cspc_ctrl_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .loop_lock(loop_lock), .deep_sleep_enter(deep_sleep_enter), .wake(wake),
    .loop_reference_sel(loop_reference_sel), .loop_enable(loop_enable), .loop_connect(loop_connect),
    .core_from_loop(core_from_loop), .core_from_ref(core_from_ref), .core_div(core_div), .usb_div(usb_div),
    .exec_hold(exec_hold));
